/* File: obcd_top.sv */
// option byte configuration decoder: capture, decode, programming port and protection gate
`timescale 1ns/1ps
`default_nettype none
`include "obcd_consts.svh"
module obcd_top
   import obcd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // mode pins from outside
   input wire logic in_circuit_programming_mode,
   input wire logic test_mode,
   // non-volatile store
   input wire logic [7:0] nv_opt_byte0,
   input wire logic [7:0] nv_opt_byte1,
   output logic nv_prog_valid,
   output logic nv_prog_index,
   output logic [7:0] nv_prog_data,
   output logic nv_opt_erase,
   output logic mem_erase_req,
   input wire logic mem_erase_done,
   // program memory access gate
   output logic pm_access_block,
   // decoded settings
   output logic halt_reset_when_watchdog_on,
   output logic watchdog_software_activation,
   output logic clock_source_select,
   output logic low_voltage_detector,
   output logic auxiliary_voltage_detector,
   output logic [12:0] reset_phase_cycles,
   output logic input_halving_divider,
   output logic readout_protection_on,
   output logic [2:0] package_select,
   output logic package_reserved,
   output logic motor_out_level,
   output logic motor_out_oe_n,
   output logic config_valid
);
   obcd_cfg_if cfg ();

   logic [7:0] opt0_q;
   logic [7:0] opt1_q;
   logic captured_q;
   logic icp_meta_q, icp_q;
   logic test_meta_q, test_q;
   obcd_erase_state_t erase_q, erase_d;

   // axi state
   logic aw_held_q, w_held_q;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic wr_fire;
   logic prog_ok;
   logic erase_start;

   // two-flop synchronisers for the mode pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         icp_meta_q <= 1'b0;
         icp_q <= 1'b0;
         test_meta_q <= 1'b0;
         test_q <= 1'b0;
      end else begin
         icp_meta_q <= in_circuit_programming_mode;
         icp_q <= icp_meta_q;
         test_meta_q <= test_mode;
         test_q <= test_meta_q;
      end
   end

   // bytes start as erased ones and load from the store once, at the first edge after release;
   // later programming changes the store but not these until the next reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt0_q <= `OBCD_ERASED_BYTE;
         opt1_q <= `OBCD_ERASED_BYTE;
         captured_q <= 1'b0;
      end else if (!captured_q) begin
         opt0_q <= nv_opt_byte0;
         opt1_q <= nv_opt_byte1;
         captured_q <= 1'b1;
      end
   end

   assign cfg.opt_byte0 = opt0_q;
   assign cfg.opt_byte1 = opt1_q;

   obcd_decoder u_decoder (
      .cfg (cfg)
   );

   assign halt_reset_when_watchdog_on = cfg.halt_reset_when_watchdog_on;
   assign watchdog_software_activation = cfg.watchdog_software_activation;
   assign clock_source_select = cfg.clock_source_select;
   assign low_voltage_detector = cfg.low_voltage_detector;
   assign auxiliary_voltage_detector = cfg.auxiliary_voltage_detector;
   assign reset_phase_cycles = cfg.reset_phase_cycles;
   assign input_halving_divider = cfg.input_halving_divider;
   assign readout_protection_on = cfg.readout_protection_on;
   assign package_select = cfg.package_select;
   assign package_reserved = cfg.package_reserved;
   assign motor_out_level = cfg.motor_out_level;
   assign motor_out_oe_n = ~cfg.motor_out_drive; // low while driving
   assign config_valid = captured_q;

   // protection locks program memory out in test and programming modes
   assign pm_access_block = cfg.readout_protection_on && (test_q || icp_q);

   // option byte and command writes are taken only in programming mode and with no erase running
   assign prog_ok = icp_q && (erase_q == OBCD_ER_IDLE);

   // write address and data channels are taken independently and held until both are in
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata[7:0];
         wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   // write decode and response; a blocked option write gets slverr and changes nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `OBCD_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         unique case ({2'b00, awaddr_q[7:2]})
            `OBCD_OFF_OPT0 >> 2, `OBCD_OFF_OPT1 >> 2, `OBCD_OFF_CMD >> 2: begin
               bresp_q <= prog_ok ? `OBCD_RESP_OKAY : `OBCD_RESP_SLVERR;
            end
            `OBCD_OFF_STATUS >> 2: begin
               bresp_q <= `OBCD_RESP_OKAY; // read-only, write ignored
            end
            default: begin
               bresp_q <= `OBCD_RESP_DECERR;
            end
         endcase
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // programming strobe to the store, one cycle per accepted byte write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nv_prog_valid <= 1'b0;
         nv_prog_index <= 1'b0;
         nv_prog_data <= 8'h00;
      end else begin
         nv_prog_valid <= wr_fire && prog_ok && wstrb0_q &&
                          (awaddr_q == `OBCD_OFF_OPT0 || awaddr_q == `OBCD_OFF_OPT1);
         if (wr_fire) begin
            nv_prog_index <= (awaddr_q == `OBCD_OFF_OPT1);
            nv_prog_data <= wdata_q;
         end
      end
   end

   assign erase_start = wr_fire && prog_ok && wstrb0_q && (awaddr_q == `OBCD_OFF_CMD) &&
                        wdata_q[`OBCD_CMD_ERASE];

   // erase sequencer: with protection on, user memory goes first so code cannot be
   // extracted by clearing the protection bit alone
   always_comb begin
      erase_d = erase_q;
      unique case (erase_q)
         OBCD_ER_IDLE: begin
            if (erase_start) begin
               erase_d = cfg.readout_protection_on ? OBCD_ER_MEM : OBCD_ER_OPT;
            end
         end
         OBCD_ER_MEM: begin
            if (mem_erase_done) begin
               erase_d = OBCD_ER_OPT;
            end
         end
         OBCD_ER_OPT: begin
            erase_d = OBCD_ER_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         erase_q <= OBCD_ER_IDLE;
      end else begin
         erase_q <= erase_d;
      end
   end

   assign mem_erase_req = (erase_q == OBCD_ER_MEM); // held until done
   assign nv_opt_erase = (erase_q == OBCD_ER_OPT); // one-cycle pulse

   // read channel: one read at a time, data one cycle after address
   assign s_axi_arready = !rvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= `OBCD_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= `OBCD_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         unique case ({2'b00, s_axi_araddr[7:2]})
            `OBCD_OFF_OPT0 >> 2: begin
               if (icp_q) begin
                  rdata_q <= {24'h00_0000, nv_opt_byte0};
               end else begin
                  rresp_q <= `OBCD_RESP_SLVERR;
               end
            end
            `OBCD_OFF_OPT1 >> 2: begin
               if (icp_q) begin
                  rdata_q <= {24'h00_0000, nv_opt_byte1};
               end else begin
                  rresp_q <= `OBCD_RESP_SLVERR;
               end
            end
            `OBCD_OFF_STATUS >> 2: begin
               // live decoded state, not the raw bytes
               rdata_q <= {13'h0000, test_q, icp_q, (erase_q != OBCD_ER_IDLE),
                           2'h0, captured_q, cfg.readout_protection_on, cfg.input_halving_divider,
                           cfg.low_voltage_detector, cfg.auxiliary_voltage_detector,
                           cfg.clock_source_select, cfg.watchdog_software_activation,
                           cfg.halt_reset_when_watchdog_on, cfg.package_reserved,
                           cfg.package_select, cfg.motor_out_drive, cfg.motor_out_level};
            end
            `OBCD_OFF_CMD >> 2: begin
               rdata_q <= 32'h0000_0000; // write-only
            end
            default: begin
               rresp_q <= `OBCD_RESP_DECERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
endmodule : obcd_top
`default_nettype wire

/* File: obcd_consts.svh */
// constants for the option byte configuration decoder: offsets, fields, reset values, counts
`ifndef OBCD_CONSTS_SVH
`define OBCD_CONSTS_SVH

// register byte offsets
`define OBCD_OFF_OPT0 8'h00
`define OBCD_OFF_OPT1 8'h04
`define OBCD_OFF_STATUS 8'h08
`define OBCD_OFF_CMD 8'h0C

// erased non-volatile content
`define OBCD_ERASED_BYTE 8'hFF

// option byte 0 field positions
`define OBCD_B0_HALT_RST 7
`define OBCD_B0_WATCHDOG_SOFTWARE_ACTIVATION 6
`define OBCD_B0_CLK_SEL 5
`define OBCD_B0_VD_HI 4
`define OBCD_B0_VD_LO 3
`define OBCD_B0_RST_LEN 2
`define OBCD_B0_DIV 1
`define OBCD_B0_PROT 0

// option byte 1 field positions
`define OBCD_B1_PKG_HI 7
`define OBCD_B1_PKG_LO 5
`define OBCD_B1_MCO_HI 1
`define OBCD_B1_MCO_LO 0

// field codes
`define OBCD_VD_BOTH 2'h0
`define OBCD_VD_LOW_ONLY 2'h1
`define OBCD_PKG_32 3'h0
`define OBCD_PKG_44 3'h1
`define OBCD_MCO_LOW 2'h1
`define OBCD_MCO_HIGH 2'h2

// reset phase lengths in cpu cycles
`define OBCD_RST_LONG 13'h1000
`define OBCD_RST_SHORT 13'h0100

// command and status bits
`define OBCD_CMD_ERASE 0
`define OBCD_ST_BUSY 16
`define OBCD_ST_PROG 17
`define OBCD_ST_TEST 18

// axi responses
`define OBCD_RESP_OKAY 2'h0
`define OBCD_RESP_SLVERR 2'h2
`define OBCD_RESP_DECERR 2'h3

`endif

/* File: obcd_pkg.sv */
// types shared by the option byte configuration decoder
package obcd_pkg;
   typedef enum logic [1:0] {
      OBCD_ER_IDLE,
      OBCD_ER_MEM,
      OBCD_ER_OPT
   } obcd_erase_state_t;
endpackage : obcd_pkg

/* File: obcd_cfg_if.sv */
// interface carrying raw option bytes in and decoded settings out of the decoder
`timescale 1ns/1ps
`default_nettype none
interface obcd_cfg_if;
   logic [7:0] opt_byte0;
   logic [7:0] opt_byte1;
   logic halt_reset_when_watchdog_on;
   logic watchdog_software_activation;
   logic clock_source_select;
   logic low_voltage_detector;
   logic auxiliary_voltage_detector;
   logic [12:0] reset_phase_cycles;
   logic input_halving_divider;
   logic readout_protection_on;
   logic [2:0] package_select;
   logic package_reserved;
   logic motor_out_drive;
   logic motor_out_level;
   modport src (output opt_byte0, output opt_byte1,
                input halt_reset_when_watchdog_on, input watchdog_software_activation,
                input clock_source_select, input low_voltage_detector,
                input auxiliary_voltage_detector, input reset_phase_cycles,
                input input_halving_divider, input readout_protection_on,
                input package_select, input package_reserved,
                input motor_out_drive, input motor_out_level);
   modport dec (input opt_byte0, input opt_byte1,
                output halt_reset_when_watchdog_on, output watchdog_software_activation,
                output clock_source_select, output low_voltage_detector,
                output auxiliary_voltage_detector, output reset_phase_cycles,
                output input_halving_divider, output readout_protection_on,
                output package_select, output package_reserved,
                output motor_out_drive, output motor_out_level);
endinterface : obcd_cfg_if
`default_nettype wire

/* File: obcd_decoder.sv */
// combinational decode of the two captured option bytes into settings
`timescale 1ns/1ps
`default_nettype none
`include "obcd_consts.svh"
module obcd_decoder
   import obcd_pkg::*;
(
   obcd_cfg_if.dec cfg
);
   logic [1:0] vd;
   logic [1:0] motor_output_reset_state;
   logic pll_sel;

   assign vd = cfg.opt_byte0[`OBCD_B0_VD_HI:`OBCD_B0_VD_LO];
   assign motor_output_reset_state = cfg.opt_byte1[`OBCD_B1_MCO_HI:`OBCD_B1_MCO_LO];
   assign pll_sel = ~cfg.opt_byte0[`OBCD_B0_CLK_SEL];

   // watchdog and clock fields pass straight through
   assign cfg.halt_reset_when_watchdog_on = cfg.opt_byte0[`OBCD_B0_HALT_RST];
   assign cfg.watchdog_software_activation = cfg.opt_byte0[`OBCD_B0_WATCHDOG_SOFTWARE_ACTIVATION];
   assign cfg.clock_source_select = cfg.opt_byte0[`OBCD_B0_CLK_SEL];
   assign cfg.input_halving_divider = ~cfg.opt_byte0[`OBCD_B0_DIV]; // 1 = divider in use
   assign cfg.readout_protection_on = ~cfg.opt_byte0[`OBCD_B0_PROT];

   // both 10 and 11 switch the detectors off
   assign cfg.low_voltage_detector = (vd == `OBCD_VD_BOTH) || (vd == `OBCD_VD_LOW_ONLY);
   assign cfg.auxiliary_voltage_detector = (vd == `OBCD_VD_BOTH);

   // the pll needs the long delay however the length bit is set
   assign cfg.reset_phase_cycles = (pll_sel || !cfg.opt_byte0[`OBCD_B0_RST_LEN]) ?
                                   `OBCD_RST_LONG : `OBCD_RST_SHORT;

   // package code; bits 4:2 of byte 1 are never looked at
   assign cfg.package_select = cfg.opt_byte1[`OBCD_B1_PKG_HI:`OBCD_B1_PKG_LO];
   assign cfg.package_reserved = !(cfg.package_select == `OBCD_PKG_32 ||
                                   cfg.package_select == `OBCD_PKG_44);

   // 00 and 11 leave the motor outputs floating
   assign cfg.motor_out_drive = (motor_output_reset_state == `OBCD_MCO_LOW) || (motor_output_reset_state == `OBCD_MCO_HIGH);
   assign cfg.motor_out_level = (motor_output_reset_state == `OBCD_MCO_HIGH);
endmodule : obcd_decoder
`default_nettype wire

/* File: obcd_nv_model.sv */
// behavioural non-volatile option store and program memory wipe model
`timescale 1ns/1ps
`default_nettype none
module obcd_nv_model
   import obcd_pkg::*;
#(
   parameter int ERASE_LAT = 5
)
(
   input wire logic aclk,
   input wire logic prog_valid,
   input wire logic prog_index,
   input wire logic [7:0] prog_data,
   input wire logic opt_erase,
   input wire logic erase_req,
   output logic erase_done,
   output logic [7:0] byte0,
   output logic [7:0] byte1,
   output int wipes
);
   logic [7:0] cnt_q;
   // blank store reads all ones; contents survive a device reset
   initial begin
      byte0 = 8'hFF;
      byte1 = 8'hFF;
      wipes = 0;
      cnt_q = 8'h00;
      erase_done = 1'b0;
   end
   // option erase returns every bit to one, programming replaces one byte
   always @(posedge aclk) begin
      if (opt_erase) begin
         byte0 <= 8'hFF;
         byte1 <= 8'hFF;
      end else if (prog_valid) begin
         if (prog_index) byte1 <= prog_data;
         else byte0 <= prog_data;
      end
   end
   // wipe takes ERASE_LAT+1 cycles; done pulses once, a slow answer on purpose
   always @(posedge aclk) begin
      if (!erase_req) begin
         cnt_q <= 8'h00;
         erase_done <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         erase_done <= (cnt_q == ERASE_LAT[7:0]);
         if (cnt_q == ERASE_LAT[7:0]) wipes <= wipes + 1;
      end
   end
endmodule : obcd_nv_model
`default_nettype wire

/* File: obcd_top_props.sv */
// concurrent checks on the option byte decoder ports
`timescale 1ns/1ps
`default_nettype none
module obcd_top_props
   import obcd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_circuit_programming_mode,
   input wire logic [7:0] nv_opt_byte0,
   input wire logic [7:0] nv_opt_byte1,
   input wire logic nv_prog_valid,
   input wire logic nv_opt_erase,
   input wire logic mem_erase_req,
   input wire logic mem_erase_done,
   input wire logic pm_access_block,
   input wire logic halt_reset_when_watchdog_on,
   input wire logic watchdog_software_activation,
   input wire logic clock_source_select,
   input wire logic low_voltage_detector,
   input wire logic auxiliary_voltage_detector,
   input wire logic [12:0] reset_phase_cycles,
   input wire logic input_halving_divider,
   input wire logic readout_protection_on,
   input wire logic [2:0] package_select,
   input wire logic package_reserved,
   input wire logic motor_out_level,
   input wire logic motor_out_oe_n,
   input wire logic config_valid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_defaults: assert property ($past(!aresetn) |-> halt_reset_when_watchdog_on && clock_source_select
      && reset_phase_cycles == 13'h0100 && !readout_protection_on && motor_out_oe_n && !config_valid)
      else $error("settings during reset are not the erased ones");
   a_capture_byte0: assert property ($rose(config_valid) |-> halt_reset_when_watchdog_on == $past(nv_opt_byte0[7])
      && watchdog_software_activation == $past(nv_opt_byte0[6]) && clock_source_select == $past(nv_opt_byte0[5])
      && input_halving_divider == !$past(nv_opt_byte0[1]) && readout_protection_on == !$past(nv_opt_byte0[0]))
      else $error("byte0 fields not decoded at capture");
   a_capture_motor: assert property ($rose(config_valid) |-> motor_out_level == ($past(nv_opt_byte1[1:0]) == 2'h2)
      && motor_out_oe_n == ($past(nv_opt_byte1[1:0]) == 2'h0 || $past(nv_opt_byte1[1:0]) == 2'h3))
      else $error("motor output state not decoded");
   a_vd_nested: assert property (auxiliary_voltage_detector |-> low_voltage_detector)
      else $error("auxiliary detector on without low voltage detector");
   a_pll_long_rst: assert property (!clock_source_select |-> reset_phase_cycles == 13'h1000)
      else $error("pll clock without long reset phase");
   a_pkg_reserved: assert property (package_reserved == (package_select > 3'h1))
      else $error("package reserved flag wrong");
   a_hold_stable: assert property (config_valid && $past(config_valid) |-> $stable(package_select)
      && $stable(reset_phase_cycles) && $stable(readout_protection_on) && $stable(motor_out_oe_n))
      else $error("settings changed between resets");
   a_block_gate: assert property (readout_protection_on && in_circuit_programming_mode [*4] |-> pm_access_block)
      else $error("protected memory not blocked in programming mode");
   a_free_unprot: assert property (!readout_protection_on |-> !pm_access_block && !mem_erase_req)
      else $error("block or wipe without protection");
   a_wipe_first: assert property (nv_opt_erase && readout_protection_on |-> $past(mem_erase_done))
      else $error("option erase before memory wipe");
   a_req_held: assert property (mem_erase_req && !mem_erase_done |=> mem_erase_req)
      else $error("wipe request dropped early");
   a_prog_icp: assert property (nv_prog_valid |-> $past(in_circuit_programming_mode, 3))
      else $error("store programmed outside programming mode");
   c_capture: cover property ($rose(config_valid));
   c_wipe: cover property (mem_erase_req ##1 mem_erase_done);
   c_block: cover property (pm_access_block);
endmodule : obcd_top_props
bind obcd_top obcd_top_props u_props (.*);
`default_nettype wire

/* File: tb_option_byte_config_decoder.sv */
// self-checking bench for the option byte configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "obcd_consts.svh"
module tb_option_byte_config_decoder;
   import obcd_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, in_circuit_programming_mode, test_mode;
   logic [7:0] s_axi_awaddr, s_axi_araddr, nv_opt_byte0, nv_opt_byte1, nv_prog_data;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot, package_select;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic nv_prog_valid, nv_prog_index, nv_opt_erase, mem_erase_req, mem_erase_done, pm_access_block;
   logic halt_reset_when_watchdog_on, watchdog_software_activation, clock_source_select, low_voltage_detector;
   logic auxiliary_voltage_detector, input_halving_divider, readout_protection_on, package_reserved;
   logic motor_out_level, motor_out_oe_n, config_valid;
   logic [12:0] reset_phase_cycles;
   logic [7:0] b0s [5] = '{8'h00, 8'h2C, 8'h14, 8'h3B, 8'hFE};
   logic [7:0] b1s [5] = '{8'h01, 8'h22, 8'h7F, 8'h1C, 8'h80};
   int n_mismatch, cmp_count, wipes, k;

   obcd_top dut (.*);
   obcd_nv_model #(.ERASE_LAT(5)) nvm (.aclk(aclk), .prog_valid(nv_prog_valid), .prog_index(nv_prog_index),
      .prog_data(nv_prog_data), .opt_erase(nv_opt_erase), .erase_req(mem_erase_req), .erase_done(mem_erase_done),
      .byte0(nv_opt_byte0), .byte1(nv_opt_byte1), .wipes(wipes));

   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic hang;
      n_mismatch++;
      $display("mismatch wait expected answer seen timeout");
      end_of_test();
   endtask : hang

   // sixteen cycles of reset, then settle past the capture edge
   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask : do_reset

   task automatic set_icp(input logic v);
      @(posedge aclk);
      in_circuit_programming_mode <= v;
      repeat (4) @(posedge aclk);
   endtask : set_icp

   // ready sampled mid-cycle is what the next rising edge sees
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      for (i = 0; i < 64 && !b; i++) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      if (!b) hang();
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      logic ar, b;
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      b = 1'b0;
      for (i = 0; i < 64 && !b; i++) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         b = (s_axi_rvalid === 1'b1);
         resp = s_axi_rresp;
         rd = s_axi_rdata;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (b) s_axi_rready <= 1'b0;
      end
      if (!b) hang();
   endtask : axi_rd

   // expected settings worked out field by field from the two bytes
   task automatic chk_dec(input logic [7:0] b0, input logic [7:0] b1);
      chk("valid", 32'h1, config_valid);
      chk("halt", b0[7], halt_reset_when_watchdog_on);
      chk("wdg", b0[6], watchdog_software_activation);
      chk("clk", b0[5], clock_source_select);
      chk("lvd", !b0[4], low_voltage_detector);
      chk("avd", b0[4:3] == 2'h0, auxiliary_voltage_detector);
      chk("rst", (b0[5] && b0[2]) ? 13'h0100 : 13'h1000, reset_phase_cycles);
      chk("div", !b0[1], input_halving_divider);
      chk("prot", !b0[0], readout_protection_on);
      chk("pkg", b1[7:5], package_select);
      chk("pkgres", b1[7:5] > 3'h1, package_reserved);
      chk("mlvl", b1[1:0] == 2'h2, motor_out_level);
      chk("moe", b1[1:0] == 2'h0 || b1[1:0] == 2'h3, motor_out_oe_n);
   endtask : chk_dec

   // outside programming mode the bytes are unreachable
   task automatic t_locked;
      axi_rd(`OBCD_OFF_OPT0);
      chk("rdresp", `OBCD_RESP_SLVERR, resp);
      axi_wr(`OBCD_OFF_OPT1, 32'h0);
      chk("wrresp", `OBCD_RESP_SLVERR, resp);
      chk("store", 8'hFF, nv_opt_byte1);
      axi_rd(8'h40);
      chk("unmapped", `OBCD_RESP_DECERR, resp);
      // erased bytes: captured, clock, watchdog, halt bits set, package 111 reserved
      axi_rd(`OBCD_OFF_STATUS);
      chk("status", 32'h0000_21FC, rd);
   endtask : t_locked

   // program both bytes, restart, and see the new settings
   task automatic t_prog(input logic [7:0] b0, input logic [7:0] b1);
      set_icp(1'b1);
      axi_wr(`OBCD_OFF_OPT0, {24'h0, b0});
      chk("wr0", `OBCD_RESP_OKAY, resp);
      axi_wr(`OBCD_OFF_OPT1, {24'h0, b1});
      chk("wr1", `OBCD_RESP_OKAY, resp);
      axi_rd(`OBCD_OFF_OPT0);
      chk("rd0", {24'h0, b0}, rd);
      set_icp(1'b0);
      do_reset();
      chk_dec(b0, b1);
   endtask : t_prog

   // erase the option bytes; protection forces a memory wipe first
   task automatic t_erase(input logic p);
      int w0, i;
      w0 = wipes;
      @(posedge aclk);
      test_mode <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("tblock", p, pm_access_block);
      test_mode <= 1'b0;
      set_icp(1'b1);
      chk("iblock", p, pm_access_block);
      axi_wr(`OBCD_OFF_CMD, 32'h1);
      chk("ersp", `OBCD_RESP_OKAY, resp);
      for (i = 0; i < 64 && nv_opt_byte0 !== 8'hFF; i++) @(negedge aclk);
      if (i == 64) hang();
      chk("wipes", w0 + (p ? 1 : 0), wipes);
      set_icp(1'b0);
      do_reset();
      chk_dec(8'hFF, 8'hFF);
   endtask : t_erase

   initial begin
      n_mismatch = 0;
      cmp_count = 0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {in_circuit_programming_mode, test_mode} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      s_axi_awprot = 3'h0;
      s_axi_arprot = 3'h0;
      do_reset();
      chk_dec(8'hFF, 8'hFF);
      t_locked();
      for (k = 0; k < 5; k++) t_prog(b0s[k], b1s[k]);
      t_erase(1'b1);
      t_prog(b0s[3], b1s[3]);
      t_erase(1'b0);
      end_of_test();
   end
endmodule : tb_option_byte_config_decoder
`default_nettype wire
